// ---- rtl/qbp_pkg.sv ----
// constants for the quasi-bidirectional port with alternate functions
package qbp_pkg;
  localparam int unsigned WIDTH = 8;
  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam real CLK_NS = 10.0;
  localparam real BOOST_NS = 20.0;
  localparam logic [1:0] BOOST_CYCLES = 2'(int'(BOOST_NS / CLK_NS));
  localparam int unsigned BIT_RXD = 0;
  localparam int unsigned BIT_TXD = 1;
  localparam int unsigned BIT_IRQ0 = 2;
  localparam int unsigned BIT_IRQ1 = 3;
  localparam int unsigned BIT_CNT0 = 4;
  localparam int unsigned BIT_CNT1 = 5;
  localparam int unsigned BIT_WRS = 6;
  localparam int unsigned BIT_RDS = 7;
endpackage

// ---- rtl/qbp_pin.sv ----
// one quasi-bidirectional pin driver: latch, strong pulldown, brief pull-up boost
`timescale 1ns/1ps
`default_nettype none
module qbp_pin (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_wdata,
  input wire logic i_alt_en,
  input wire logic i_alt_val,
  input wire logic i_pin,
  output logic o_latch,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_weak_pu,
  output logic o_pin_in
);
  typedef struct packed {
    logic latch;
    logic [1:0] boost;
    logic pin_out;
    logic pin_oe;
    logic weak_pu;
    logic pin_in;
  } qbp_pin_s;
  qbp_pin_s st, next_st;
  logic level;
  logic rising;

  always_comb begin
    next_st = st;
    if (i_wr) begin
      next_st.latch = i_wdata;
    end
    // alternate output only shows while the latch holds 1
    level = next_st.latch & (i_alt_en ? i_alt_val : 1'b1);
    rising = level & ~st.pin_out;
    if (rising) begin
      next_st.boost = qbp_pkg::BOOST_CYCLES;
    end else if (st.boost != 2'h0) begin
      next_st.boost = st.boost - 2'h1;
    end
    next_st.pin_out = level;
    // strong drive: low always, high only during the boost
    next_st.pin_oe = ~level | rising | (st.boost > 2'h1); // R3 R4
    next_st.weak_pu = level; // R1 R2
    next_st.pin_in = i_pin; // R2
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st <= '{latch: 1'b1, boost: 2'h0, pin_out: 1'b1, pin_oe: 1'b0,
              weak_pu: 1'b1, pin_in: 1'b1}; // R1
    end else begin
      st <= next_st;
    end
  end

  assign o_latch = st.latch;
  assign o_pin_out = st.pin_out;
  assign o_pin_oe = st.pin_oe;
  assign o_weak_pu = st.weak_pu;
  assign o_pin_in = st.pin_in;

  low_drive_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_wr && !i_wdata) |=> (o_pin_oe && !o_pin_out)) // R3
    else $error("written zero did not pull low");
  sequence zero_then_one;
    (o_pin_oe && !o_pin_out) ##1 (o_pin_out && o_pin_oe);
  endsequence
  boost_end_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    zero_then_one |-> ##2 (!o_pin_oe || !o_pin_out)) // R4
    else $error("pull-up boost not brief");
  boost_start_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ($rose(o_pin_out)) |-> o_pin_oe) // R4
    else $error("no strong boost on rising edge");
  weak_high_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_pin_out == o_weak_pu)) // R2
    else $error("weak pullup mismatch");
  latch_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!o_latch) |-> (!o_pin_out)) // R11
    else $error("alternate overrode low latch");
endmodule
`default_nettype wire

// ---- rtl/qbp_top.sv ----
// two quasi-bidirectional ports: address-high port and alternate-function port
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: after reset every port bit is high, held only by the weak pullup.
// R2: weak high doubles as input; external drivers win and pins read back.
// R3: writing 0 turns on a strong pulldown until 1 is written or reset.
// R4: writing 1 after 0 gives a brief strong pull-up, then weak pullup.
// R5: address port drives the high external address byte during bus cycles.
// R6: bit 0 is serial receive input, bit 1 serial transmit output.
// R7: bits 2 and 3 are external interrupt 0 and 1 inputs.
// R8: bits 4 and 5 are timer 0 and timer 1 count inputs.
// R9: bit 6 is data write strobe, bit 7 data read strobe.
// R10: low external-access selects external program memory, high selects internal.
// R11: an alternate output only drives while its port latch bit holds 1.
module qbp_top (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_a_wr,
  input wire logic [7:0] i_a_wdata,
  input wire logic i_a_bus_en,
  input wire logic [7:0] i_a_addr_hi,
  input wire logic [7:0] i_a_pin,
  output logic [7:0] o_a_latch,
  output logic [7:0] o_a_pin,
  output logic [7:0] o_a_pin_out,
  output logic [7:0] o_a_pin_oe,
  output logic [7:0] o_a_weak_pu,
  input wire logic i_b_wr,
  input wire logic [7:0] i_b_wdata,
  input wire logic i_tx_en,
  input wire logic i_serial0_transmit,
  input wire logic i_wr_strobe_n,
  input wire logic i_rd_strobe_n,
  input wire logic [7:0] i_b_pin,
  output logic [7:0] o_b_latch,
  output logic [7:0] o_b_pin,
  output logic [7:0] o_b_pin_out,
  output logic [7:0] o_b_pin_oe,
  output logic [7:0] o_b_weak_pu,
  output logic o_serial0_receive_in,
  output logic o_ext_irq_zero_in,
  output logic o_ext_irq_one_in,
  output logic o_timer_zero_count_in,
  output logic o_timer_one_count_in,
  input wire logic i_ext_access_n,
  output logic o_fetch_external
);
  typedef struct packed {
    logic fetch_external;
  } qbp_top_s;
  qbp_top_s st, next_st;
  logic [7:0] b_alt_en;
  logic [7:0] b_alt_val;

  always_comb begin
    b_alt_en = 8'h00;
    b_alt_val = 8'hff;
    b_alt_en[qbp_pkg::BIT_TXD] = i_tx_en; // R6
    b_alt_val[qbp_pkg::BIT_TXD] = i_serial0_transmit; // R6
    b_alt_en[qbp_pkg::BIT_WRS] = 1'b1; // R9
    b_alt_val[qbp_pkg::BIT_WRS] = i_wr_strobe_n; // R9
    b_alt_en[qbp_pkg::BIT_RDS] = 1'b1; // R9
    b_alt_val[qbp_pkg::BIT_RDS] = i_rd_strobe_n; // R9
  end

  always_comb begin
    next_st.fetch_external = ~i_ext_access_n; // R10
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st <= '{fetch_external: 1'b0};
    end else begin
      st <= next_st;
    end
  end
  assign o_fetch_external = st.fetch_external;

  // inputs share the synchronised pin value, so they need latch high to be seen
  assign o_serial0_receive_in = o_b_pin[qbp_pkg::BIT_RXD]; // R6
  assign o_ext_irq_zero_in = o_b_pin[qbp_pkg::BIT_IRQ0]; // R7
  assign o_ext_irq_one_in = o_b_pin[qbp_pkg::BIT_IRQ1]; // R7
  assign o_timer_zero_count_in = o_b_pin[qbp_pkg::BIT_CNT0]; // R8
  assign o_timer_one_count_in = o_b_pin[qbp_pkg::BIT_CNT1]; // R8

  for (genvar g = 0; g < qbp_pkg::WIDTH; g++) begin : g_bit
    qbp_pin u_a (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_wr(i_a_wr),
      .i_wdata(i_a_wdata[g]),
      .i_alt_en(i_a_bus_en), // R5
      .i_alt_val(i_a_addr_hi[g]), // R5
      .i_pin(i_a_pin[g]),
      .o_latch(o_a_latch[g]),
      .o_pin_out(o_a_pin_out[g]),
      .o_pin_oe(o_a_pin_oe[g]),
      .o_weak_pu(o_a_weak_pu[g]),
      .o_pin_in(o_a_pin[g])
    );
    qbp_pin u_b (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_wr(i_b_wr),
      .i_wdata(i_b_wdata[g]),
      .i_alt_en(b_alt_en[g]),
      .i_alt_val(b_alt_val[g]),
      .i_pin(i_b_pin[g]),
      .o_latch(o_b_latch[g]),
      .o_pin_out(o_b_pin_out[g]),
      .o_pin_oe(o_b_pin_oe[g]),
      .o_weak_pu(o_b_weak_pu[g]),
      .o_pin_in(o_b_pin[g])
    );
  end

  fetch_sel_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (!i_ext_access_n) |=> o_fetch_external) // R10
    else $error("external fetch not selected");
  addr_drive_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_a_bus_en && o_a_latch == 8'hff && !i_a_wr) |=> (o_a_pin_out == $past(i_a_addr_hi))) // R5
    else $error("address byte not driven");
  rx_route_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    1'b1 |=> (o_serial0_receive_in == $past(i_b_pin[qbp_pkg::BIT_RXD]))) // R6
    else $error("receive input misrouted");
  tx_route_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_tx_en && o_b_latch[qbp_pkg::BIT_TXD] && !i_b_wr)
    |=> (o_b_pin_out[qbp_pkg::BIT_TXD] == $past(i_serial0_transmit))) // R6
    else $error("transmit output misrouted");
  wr_strobe_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_b_latch[qbp_pkg::BIT_WRS] && !i_b_wr)
    |=> (o_b_pin_out[qbp_pkg::BIT_WRS] == $past(i_wr_strobe_n))) // R9
    else $error("write strobe misrouted");
  rd_strobe_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_b_latch[qbp_pkg::BIT_RDS] && !i_b_wr)
    |=> (o_b_pin_out[qbp_pkg::BIT_RDS] == $past(i_rd_strobe_n))) // R9
    else $error("read strobe misrouted");
  irq_route_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    1'b1 |=> (o_ext_irq_zero_in == $past(i_b_pin[qbp_pkg::BIT_IRQ0]))) // R7
    else $error("interrupt input misrouted");
  count_route_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    1'b1 |=> (o_timer_one_count_in == $past(i_b_pin[qbp_pkg::BIT_CNT1]))) // R8
    else $error("count input misrouted");
endmodule
`default_nettype wire

// ---- verification/qbp_far_end.sv ----
// far-end pin model: strong drive, outside driver and weak pullup resolved per pin
`timescale 1ns/1ps
`default_nettype none
module qbp_far_end (
  input wire logic i_mclk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_weak,
  input wire logic [7:0] i_ext_en,
  input wire logic [7:0] i_ext,
  output logic [7:0] o_wire
);
  logic [7:0] last;
  logic [7:0] src;
  always_ff @(posedge i_mclk) last <= o_wire;
  // a floating pin shows the inverse of its last level
  assign src = (i_ext_en & i_ext) | (~i_ext_en & i_weak) | (~i_ext_en & ~i_weak & ~last);
  assign o_wire = (i_oe & i_out) | (~i_oe & src);
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench for the two quasi-bidirectional ports
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {int k; logic [7:0] v;} qbp_note_s;
  logic clk = 1'b0, rst = 1'b1, a_wr = 1'b0, b_wr = 1'b0, bus = 1'b0, tx_en = 1'b0;
  logic tx = 1'b1, ws_n = 1'b1, rs_n = 1'b1, ea_n = 1'b1, fetch;
  logic [7:0] a_wd = 8'h00, b_wd = 8'h00, addr = 8'h00, x_en = 8'h00, x = 8'h00, v, r;
  logic [7:0] a_w, b_w, a_pin, a_out, a_oe, a_wk, b_lat, b_pin, b_out, b_oe, b_wk;
  logic [7:0] a_lat;
  logic [4:0] alt;
  logic [95:0] obs;
  qbp_note_s q[$];
  qbp_note_s n;
  int fails = 0, checks = 0, i;
  always #5 clk = ~clk;
  assign obs = {a_wk, a_oe, a_out, a_lat, 3'h0, alt, 7'h0, fetch, a_pin, b_pin, b_wk,
    b_out, b_oe, b_lat};
  qbp_top qbp_top_i (.i_mclk(clk), .i_rst(rst), .i_a_wr(a_wr), .i_a_wdata(a_wd),
    .i_a_bus_en(bus), .i_a_addr_hi(addr), .i_a_pin(a_w), .o_a_latch(a_lat), .o_a_pin(a_pin),
    .o_a_pin_out(a_out), .o_a_pin_oe(a_oe), .o_a_weak_pu(a_wk), .i_b_wr(b_wr),
    .i_b_wdata(b_wd), .i_tx_en(tx_en), .i_serial0_transmit(tx), .i_wr_strobe_n(ws_n),
    .i_rd_strobe_n(rs_n), .i_b_pin(b_w), .o_b_latch(b_lat), .o_b_pin(b_pin),
    .o_b_pin_out(b_out), .o_b_pin_oe(b_oe), .o_b_weak_pu(b_wk),
    .o_serial0_receive_in(alt[0]), .o_ext_irq_zero_in(alt[1]), .o_ext_irq_one_in(alt[2]),
    .o_timer_zero_count_in(alt[3]), .o_timer_one_count_in(alt[4]),
    .i_ext_access_n(ea_n), .o_fetch_external(fetch));
  qbp_far_end qbp_far_end_a_i (.i_mclk(clk), .i_out(a_out), .i_oe(a_oe), .i_weak(a_wk),
    .i_ext_en(8'h00), .i_ext(8'h00), .o_wire(a_w));
  qbp_far_end qbp_far_end_i (.i_mclk(clk), .i_out(b_out), .i_oe(b_oe), .i_weak(b_wk),
    .i_ext_en(x_en), .i_ext(x), .o_wire(b_w));
  task automatic cmp8(input logic [7:0] act, input logic [7:0] exp);
    checks++;
    if (act !== exp) begin
      fails++;
      $display("BAD %0t act %h exp %h", $time, act, exp);
    end
  endtask
  task automatic ex(input int k, input logic [7:0] e);
    q.push_back('{k, e});
  endtask
  task automatic wr(input logic p, input logic [7:0] d);
    @(posedge clk);
    a_wr <= ~p;
    b_wr <= p;
    a_wd <= d;
    b_wd <= d;
    @(posedge clk);
    a_wr <= 1'b0;
    b_wr <= 1'b0;
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // results settle before the falling edge
  always @(negedge clk) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      cmp8(obs[n.k*8 +: 8], n.v);
    end
  end
  initial begin
    #5000;
    fails++;
    end_of_test;
  end
  initial begin
    void'($urandom(19486));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    ex(0, 8'hff);
    ex(1, 8'h00);
    ex(3, 8'hff);
    ex(4, 8'hff);
    ex(8, 8'hff);
    ex(10, 8'h00);
    $display("reset test end");
    wr(1'b1, 8'h00);
    ex(0, 8'h00);
    ex(1, 8'hff);
    ex(2, 8'h00);
    ex(3, 8'h00);
    @(posedge clk);
    ex(4, 8'h00);
    wr(1'b1, 8'hff);
    ex(1, 8'hff);
    ex(2, 8'hff);
    ex(3, 8'hff);
    @(posedge clk);
    ex(1, 8'hff);
    @(posedge clk);
    ex(1, 8'h00);
    ex(4, 8'hff);
    $display("drive test end");
    tx_en <= 1'b1;
    x_en <= 8'h3d;
    repeat (4) begin
      v = 8'($urandom);
      r = 8'($urandom);
      x <= v;
      tx <= r[0];
      ws_n <= r[1];
      rs_n <= r[2];
      repeat (3) @(posedge clk);
      ex(7, {3'h0, v[5:2], v[0]});
      ex(4, {r[2], r[1], v[5:2], r[0], v[0]});
    end
    tx <= 1'b1;
    wr(1'b1, 8'hfd);
    repeat (3) @(posedge clk);
    ex(4, {r[2], r[1], v[5:2], 1'b0, v[0]});
    $display("alternate test end");
    wr(1'b0, 8'hff);
    bus <= 1'b1;
    repeat (3) begin
      v = 8'($urandom);
      addr <= v;
      repeat (3) @(posedge clk);
      ex(5, v);
      ex(8, 8'hff);
      ex(9, v);
      ex(10, ~v);
      ex(11, v);
    end
    for (i = 0; i < 2; i++) begin
      ea_n <= i[0];
      repeat (2) @(posedge clk);
      ex(6, {7'h0, ~i[0]});
    end
    $display("bus test end");
    @(negedge clk);
    wait (q.size() == 0);
    end_of_test;
  end
endmodule
`default_nettype wire
